// file: sres_pkg.sv
// Shared offsets, bit positions and reset values of the serial status block
package sres_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int          ADDR_W     = 2;              // Register address width
	localparam logic [1:0]  OFS_CTRL   = 2'h0;           // Serial control
	localparam logic [1:0]  OFS_STATUS = 2'h1;           // Serial status
	localparam logic [1:0]  OFS_RXDATA = 2'h2;           // Received data, read only

	// ****************************************
	// Serial control bits
	// ****************************************
	localparam int          CTL_RX_EN  = 0;              // Receiver enable
	localparam int          CTL_TX_EN  = 1;              // Transmitter enable
	localparam int          CTL_SYNC   = 2;              // Clocked synchronous mode
	localparam int          CTL_STOP2  = 3;              // Two stop bits
	localparam int          CTL_PAR_EN = 4;              // Parity check enable
	localparam int          CTL_PAR_OD = 5;              // Odd parity
	localparam logic [5:0]  CTL_RST    = 6'h00;          // Control after reset

	// ****************************************
	// Serial status bits
	// ****************************************
	localparam int          ST_TX_BUFFER_EMPTY_FLAG    = 7;              // Transmit buffer empty
	localparam int          ST_RX_BUFFER_FULL_FLAG    = 6;              // Receive buffer full
	localparam int          ST_OVERRUN_ERROR_FLAG    = 5;              // Overrun error
	localparam int          ST_FER     = 4;              // Framing error
	localparam int          ST_PER     = 3;              // Parity error
	localparam int          ST_TRANSMIT_END_FLAG    = 2;              // Transmit end
	localparam int          ST_MPB     = 1;              // Received multiprocessor bit
	localparam int          ST_TX_MULTIPROC_BIT    = 0;              // Transmitted multiprocessor bit
	localparam logic        RST_TX_BUFFER_EMPTY_FLAG   = 1'b1;           // Buffer empty after reset
	localparam logic        RST_ERR    = 1'b0;           // Error flags clear after reset
	localparam logic        RST_TRANSMIT_END_FLAG   = 1'b1;           // Transmit end after reset
	localparam logic        RST_MPB    = 1'b0;           // Multiprocessor bits after reset

endpackage

// file: sres_flag.sv
// Status flag cell cleared by software writing 0 after reading 1
`timescale 1ns/1ps
module sres_flag #(
	parameter logic RST_VAL = 1'b0                     // Value after reset
) (
	input  wire logic clk,                             // Clock
	input  wire logic srst,                            // Synchronous reset
	input  wire logic set,                             // Hardware set event
	input  wire logic hw_clr,                          // Hardware clear event
	input  wire logic rd_hit,                          // Status register read
	input  wire logic wr_hit,                          // Status register write
	input  wire logic wbit,                            // Written value of this bit
	output logic      q,                               // Flag value
	output logic      sw_clr                           // Software clear this cycle
);

	logic armed_ff;                                    // Read as 1 since last write
	logic nxt_armed;
	logic nxt_q;

	// Only a 0 written after a 1 was seen clears; a written 1 does nothing
	assign sw_clr    = wr_hit & ~wbit & armed_ff;
	// Arm on reading 1, disarm on a write without a read of 1 in the same cycle, or when flag falls
	assign nxt_armed = q & ((rd_hit & q) | (armed_ff & ~wr_hit));
	// Set wins over every clear so no event is lost
	assign nxt_q     = set | (q & ~sw_clr & ~hw_clr);

	// Flag and arm state
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			q        <= RST_VAL;
			armed_ff <= 1'b0;
		end
		else
		begin
			q        <= nxt_q;
			armed_ff <= nxt_armed;
		end
	end

endmodule

// file: sres_rxcheck.sv
// Frame check of a received character: framing and parity
`timescale 1ns/1ps
module sres_rxcheck #(
	parameter int DATA_W = 8                           // Character width
) (
	input  wire logic [DATA_W-1:0] data,               // Received character
	input  wire logic              par_bit,            // Received parity bit
	input  wire logic [1:0]        stop_bits,          // Stop bits, [0] first
	input  wire logic              sync_mode,          // Clocked synchronous mode
	input  wire logic              par_en,             // Parity check enable
	input  wire logic              par_odd,            // Odd parity
	output logic                   framing_err,        // First stop bit was 0
	output logic                   parity_err          // Parity mismatch
);

	// Count of ones over character and parity, odd gives 1
	function automatic logic ones_odd(input logic [DATA_W-1:0] d, input logic p);
		ones_odd = ^{d, p};
	endfunction

	// No stop or parity in clocked synchronous frames
	assign framing_err = ~sync_mode & ~stop_bits[0];
	assign parity_err  = ~sync_mode & par_en & (ones_odd(data, par_bit) != par_odd);

endmodule

// file: sres_status.sv
// Serial channel status flags, control and receive data register
`timescale 1ns/1ps
module sres_status #(
	parameter int DATA_W = 8                           // Character width
) (
	input  wire logic                           clk,          // Clock
	input  wire logic                           srst,         // Synchronous reset
	input  wire logic [sres_pkg::ADDR_W-1:0]    addr,         // Register address
	input  wire logic [7:0]                     wdata,        // Write data
	input  wire logic                           wr,           // Write strobe
	input  wire logic                           rd,           // Read strobe
	output logic      [7:0]                     rdata_ff,     // Read data, one cycle late
	input  wire logic                           rx_done,      // Frame received pulse
	input  wire logic [DATA_W-1:0]              rx_char,      // Received character
	input  wire logic                           rx_par,       // Received parity bit
	input  wire logic [1:0]                     rx_stop,      // Received stop bits
	input  wire logic                           rx_mpb,       // Received multiprocessor bit
	input  wire logic                           tx_load,      // Buffer moved to shifter
	input  wire logic                           tx_last_bit,  // Last bit of character sent
	input  wire logic                           dma_tx_write, // DMA wrote transmit buffer
	input  wire logic                           dma_rx_read,  // DMA read receive data
	output logic      [DATA_W-1:0]              rx_data_ff,   // Receive data register
	output logic                                rx_en_ff,     // Receiver enable
	output logic                                tx_en_ff,     // Transmitter enable
	output logic                                sync_ff,      // Clocked synchronous mode
	output logic                                stop2_ff,     // Two stop bits
	output logic                                tx_mpb_ff,    // Multiprocessor bit to send
	output logic                                rx_halt_ff,   // Reception blocked
	output logic                                tx_halt_ff    // Sync transmission halted
);

	// ****************************************
	// Parameter check
	// ****************************************
	if (DATA_W < 5 || DATA_W > 8)
	begin : g_bad_width
		$error("DATA_W must be 5 to 8");
	end

	// ****************************************
	// Register decode
	// ****************************************
	logic       par_en_ff;                             // Parity check enable
	logic       par_odd_ff;                            // Odd parity
	logic       transmit_end_flag_ff;                               // Transmit end flag
	logic       mpb_ff;                                // Received multiprocessor bit
	logic       wr_ctrl;                               // Control write
	logic       wr_stat;                               // Status write
	logic       rd_stat;                               // Status read
	logic [7:0] status_val;                            // Status as read
	logic [7:0] nxt_rdata;

	assign wr_ctrl = wr & (addr == sres_pkg::OFS_CTRL);
	assign wr_stat = wr & (addr == sres_pkg::OFS_STATUS);
	assign rd_stat = rd & (addr == sres_pkg::OFS_STATUS);

	// ****************************************
	// Flag cells
	// ****************************************
	logic tx_buffer_empty_flag_q, rx_buffer_full_flag_q, overrun_error_flag_q, fer_q, per_q;        // Flag values
	logic tx_buffer_empty_flag_sw_clr;                                 // Software cleared buffer empty
	logic fer_det, per_det;                            // Checker results
	logic rx_take;                                     // Frame accepted for storage
	logic rx_good;                                     // Accepted frame without error
	logic rx_bad;                                      // Accepted frame with error
	logic err_any;                                     // Any error flag standing

	sres_rxcheck #(
		.DATA_W      (DATA_W)
	) u_check (
		.data        (rx_char),
		.par_bit     (rx_par),
		.stop_bits   (rx_stop),
		.sync_mode   (sync_ff),
		.par_en      (par_en_ff),
		.par_odd     (par_odd_ff),
		.framing_err (fer_det),
		.parity_err  (per_det)
	);

	// Errors block reception; a disabled receiver takes nothing so flags stay
	assign err_any = overrun_error_flag_q | fer_q | per_q;
	// Overrun: full buffer keeps old character, new one dropped
	assign rx_take = rx_done & rx_en_ff & ~err_any & ~rx_buffer_full_flag_q;
	assign rx_bad  = rx_take & (fer_det | per_det);
	assign rx_good = rx_take & ~fer_det & ~per_det;

	// Buffer empty: set while transmitter off or on load
	sres_flag #(.RST_VAL(sres_pkg::RST_TX_BUFFER_EMPTY_FLAG)) u_tx_buffer_empty_flag (
		.clk    (clk),
		.srst   (srst),
		.set    (~tx_en_ff | tx_load),
		.hw_clr (dma_tx_write),
		.rd_hit (rd_stat),
		.wr_hit (wr_stat),
		.wbit   (wdata[sres_pkg::ST_TX_BUFFER_EMPTY_FLAG]),
		.q      (tx_buffer_empty_flag_q),
		.sw_clr (tx_buffer_empty_flag_sw_clr)
	);

	// Receive full only on a clean frame
	sres_flag #(.RST_VAL(sres_pkg::RST_ERR)) u_rx_buffer_full_flag (
		.clk    (clk),
		.srst   (srst),
		.set    (rx_good),
		.hw_clr (dma_rx_read),
		.rd_hit (rd_stat),
		.wr_hit (wr_stat),
		.wbit   (wdata[sres_pkg::ST_RX_BUFFER_FULL_FLAG]),
		.q      (rx_buffer_full_flag_q),
		.sw_clr ()
	);

	// Overrun on a frame that lands while full
	sres_flag #(.RST_VAL(sres_pkg::RST_ERR)) u_overrun_error_flag (
		.clk    (clk),
		.srst   (srst),
		.set    (rx_done & rx_en_ff & ~err_any & rx_buffer_full_flag_q),
		.hw_clr (1'b0),
		.rd_hit (rd_stat),
		.wr_hit (wr_stat),
		.wbit   (wdata[sres_pkg::ST_OVERRUN_ERROR_FLAG]),
		.q      (overrun_error_flag_q),
		.sw_clr ()
	);

	// Framing error, cleared only by software
	sres_flag #(.RST_VAL(sres_pkg::RST_ERR)) u_fer (
		.clk    (clk),
		.srst   (srst),
		.set    (rx_take & fer_det),
		.hw_clr (1'b0),
		.rd_hit (rd_stat),
		.wr_hit (wr_stat),
		.wbit   (wdata[sres_pkg::ST_FER]),
		.q      (fer_q),
		.sw_clr ()
	);

	// Parity error, cleared only by software
	sres_flag #(.RST_VAL(sres_pkg::RST_ERR)) u_per (
		.clk    (clk),
		.srst   (srst),
		.set    (rx_take & per_det),
		.hw_clr (1'b0),
		.rd_hit (rd_stat),
		.wr_hit (wr_stat),
		.wbit   (wdata[sres_pkg::ST_PER]),
		.q      (per_q),
		.sw_clr ()
	);

	// ****************************************
	// Transmit end and multiprocessor bits
	// ****************************************
	logic transmit_end_flag_set;                                    // Transmit end set term
	logic transmit_end_flag_clr;                                    // Transmit end clear term
	logic nxt_transmit_end_flag;

	assign transmit_end_flag_set = ~tx_en_ff | (tx_last_bit & tx_buffer_empty_flag_q);
	assign transmit_end_flag_clr = tx_buffer_empty_flag_sw_clr | dma_tx_write;
	// Set wins so a disabled transmitter keeps it high
	assign nxt_transmit_end_flag = transmit_end_flag_set | (transmit_end_flag_ff & ~transmit_end_flag_clr);

	// Status image as software reads it
	assign status_val = {tx_buffer_empty_flag_q, rx_buffer_full_flag_q, overrun_error_flag_q, fer_q, per_q, transmit_end_flag_ff, mpb_ff, tx_mpb_ff};

	// Read mux; unmapped address reads zero
	assign nxt_rdata = ~rd ? 8'h00 :
		(addr == sres_pkg::OFS_CTRL)   ? {2'h0, par_odd_ff, par_en_ff, stop2_ff, sync_ff,
			tx_en_ff, rx_en_ff} :
		(addr == sres_pkg::OFS_STATUS) ? status_val :
		(addr == sres_pkg::OFS_RXDATA) ? 8'(rx_data_ff) : 8'h00;

	// ****************************************
	// Registers
	// ****************************************
	// Control register and read data
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			{par_odd_ff, par_en_ff, stop2_ff, sync_ff, tx_en_ff, rx_en_ff} <= sres_pkg::CTL_RST;
			rdata_ff <= 8'h00;
		end
		else
		begin
			if (wr_ctrl)
			begin
				{par_odd_ff, par_en_ff, stop2_ff, sync_ff, tx_en_ff, rx_en_ff} <= wdata[5:0];
			end
			rdata_ff <= nxt_rdata;
		end
	end

	// Status bits owned here and received data
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			transmit_end_flag_ff    <= sres_pkg::RST_TRANSMIT_END_FLAG;
			mpb_ff     <= sres_pkg::RST_MPB;
			tx_mpb_ff  <= sres_pkg::RST_MPB;
			rx_data_ff <= '0;
		end
		else
		begin
			transmit_end_flag_ff <= nxt_transmit_end_flag;
			// Bad frames still land in the data register
			if (rx_take)
			begin
				rx_data_ff <= rx_char;
				mpb_ff     <= rx_mpb;
			end
			if (wr_stat)
			begin
				tx_mpb_ff <= wdata[sres_pkg::ST_TX_MULTIPROC_BIT];
			end
		end
	end

	// Halt outputs lag the flags by one cycle
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rx_halt_ff <= 1'b0;
			tx_halt_ff <= 1'b0;
		end
		else
		begin
			rx_halt_ff <= err_any;
			tx_halt_ff <= err_any & sync_ff;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_overrun_error_flag_set;
		rx_done && rx_en_ff && !err_any && rx_buffer_full_flag_q |=> overrun_error_flag_q && $stable(rx_data_ff);
	endproperty
	a_overrun_error_flag_set: assert property (p_overrun_error_flag_set) else $error("overrun not flagged");

	property p_fer_set;
		rx_take && !sync_ff && !rx_stop[0] |=> fer_q && !rx_buffer_full_flag_q;
	endproperty
	a_fer_set: assert property (p_fer_set) else $error("framing error missed");

	property p_stop2_ign;
		rx_take && rx_stop == 2'b01 && !per_det |=> !fer_q && rx_buffer_full_flag_q;
	endproperty
	a_stop2_ign: assert property (p_stop2_ign) else $error("second stop checked");

	property p_bad_data;
		rx_bad |=> rx_data_ff == $past(rx_char) && !rx_buffer_full_flag_q;
	endproperty
	a_bad_data: assert property (p_bad_data) else $error("bad frame data wrong");

	property p_blocked;
		(fer_q || per_q) && rx_done |=> $stable(rx_data_ff) && $stable(mpb_ff) && rx_halt_ff;
	endproperty
	a_blocked: assert property (p_blocked) else $error("reception not blocked");

	property p_fer_keep;
		fer_q && !(wr_stat && !wdata[sres_pkg::ST_FER]) |=> fer_q;
	endproperty
	a_fer_keep: assert property (p_fer_keep) else $error("framing flag lost");

	property p_per_w1;
		!per_q && wr_stat && wdata[sres_pkg::ST_PER] && !rx_take |=> !per_q;
	endproperty
	a_per_w1: assert property (p_per_w1) else $error("parity flag set by write");

	property p_per_clr;
		rd_stat && per_q ##1 !wr_stat ##1
			wr_stat && !wdata[sres_pkg::ST_PER] && !rx_take |=> !per_q;
	endproperty
	a_per_clr: assert property (p_per_clr) else $error("parity flag not cleared");

	property p_transmit_end_flag_te;
		!tx_en_ff [*2] |=> transmit_end_flag_ff [*2];
	endproperty
	a_transmit_end_flag_te: assert property (p_transmit_end_flag_te) else $error("end flag low while disabled");

	property p_mpb_hold;
		!rx_en_ff |=> $stable(mpb_ff) && $stable(rx_data_ff);
	endproperty
	a_mpb_hold: assert property (p_mpb_hold) else $error("mpb changed while disabled");

	property p_tx_multiproc_bit;
		wr_stat |=> tx_mpb_ff == $past(wdata[sres_pkg::ST_TX_MULTIPROC_BIT]);
	endproperty
	a_tx_multiproc_bit: assert property (p_tx_multiproc_bit) else $error("tx mpb not stored");

endmodule

// file: sres_station.sv
// Remote serial station model driving frame and transmit events into the status block
`timescale 1ns/1ps
module sres_station (
	input  wire logic       clk,          // Peripheral clock
	output logic            rx_done,      // Frame finished pulse
	output logic      [7:0] rx_char,      // Received character
	output logic            rx_par,       // Received parity bit
	output logic      [1:0] rx_stop,      // Received stop bits, [0] first
	output logic            rx_mpb,       // Received multiprocessor bit
	output logic      [3:0] ev            // Pulses: load, last bit, dma write, dma read
);
	// ****************************************
	// Idle values
	// ****************************************
	// Fields are not meaningful outside a frame, so they do not start at zero
	initial
	begin
		rx_done = 1'b0;
		rx_char = 8'ha5;
		rx_par  = 1'b1;
		rx_stop = 2'h2;
		rx_mpb  = 1'b1;
		ev      = 4'h0;
	end

	// One frame: fields valid only beside the done pulse, inverted afterwards
	task automatic frame(input logic [7:0] c, input logic p, input logic [1:0] s, input logic m);
		@(posedge clk);
		rx_done <= 1'b1;
		rx_char <= c;
		rx_par  <= p;
		rx_stop <= s;
		rx_mpb  <= m;
		@(posedge clk);
		rx_done <= 1'b0;
		rx_char <= ~c;
		rx_par  <= ~p;
		rx_stop <= ~s;
		rx_mpb  <= ~m;
	endtask

	// One-cycle transmit side or dma event
	task automatic pulse(input int k);
		@(posedge clk);
		ev[k] <= 1'b1;
		@(posedge clk);
		ev    <= 4'h0;
	endtask
endmodule

// file: tb_top.sv
// Self-checking testbench of the serial status block
`timescale 1ns/1ps
`define CHK(g, e, m) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("wrong value at %0t: %s", $time, m); end end
module tb_top;
	logic       clk = 1'b0;     // 50 MHz clock
	logic       srst = 1'b1;    // Synchronous reset
	logic [1:0] addr = 2'h0;    // Register address
	logic [7:0] wdata = 8'h00;  // Write data
	logic       wr = 1'b0;      // Write strobe
	logic       rd = 1'b0;      // Read strobe
	logic [7:0] rdata_ff;       // Read data
	logic       rx_done;        // Frame pulse
	logic [7:0] rx_char;        // Character
	logic       rx_par;         // Parity bit
	logic [1:0] rx_stop;        // Stop bits
	logic       rx_mpb;         // Multiprocessor bit
	logic [3:0] ev;             // Transmit and dma events
	logic [7:0] rx_data_ff;     // Receive data register
	logic       tx_mpb_ff;      // Bit inserted in transmit frames
	logic       rx_en_ff;       // Receiver enable
	logic       tx_en_ff;       // Transmitter enable
	logic       sync_ff;        // Clocked synchronous mode
	logic       stop2_ff;       // Two stop bits
	logic       rx_halt_ff;     // Reception blocked
	logic       tx_halt_ff;     // Sync transmission halted
	int         n_fail = 0;     // Mismatches
	int         total_checks = 0; // Comparisons

	always #10 clk = ~clk;

	sres_station st_u (.clk(clk), .rx_done(rx_done), .rx_char(rx_char), .rx_par(rx_par),
		.rx_stop(rx_stop), .rx_mpb(rx_mpb), .ev(ev));

	sres_status #(.DATA_W(8)) dut_u (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_ff(rdata_ff), .rx_done(rx_done), .rx_char(rx_char),
		.rx_par(rx_par), .rx_stop(rx_stop), .rx_mpb(rx_mpb), .tx_load(ev[0]),
		.tx_last_bit(ev[1]), .dma_tx_write(ev[2]), .dma_rx_read(ev[3]),
		.rx_data_ff(rx_data_ff), .rx_en_ff(rx_en_ff), .tx_en_ff(tx_en_ff),
		.sync_ff(sync_ff), .stop2_ff(stop2_ff),
		.tx_mpb_ff(tx_mpb_ff), .rx_halt_ff(rx_halt_ff), .tx_halt_ff(tx_halt_ff));

	// ****************************************
	// Bus tasks
	// ****************************************
	task automatic wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [1:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1 `CHK(rdata_ff, e, "register read")
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_reset;
		rd_reg(sres_pkg::OFS_STATUS, 8'h84);
		rd_reg(sres_pkg::OFS_CTRL, 8'h00);
		rd_reg(2'h3, 8'h00);
		`CHK({rx_en_ff, tx_en_ff, sync_ff, stop2_ff}, 4'h0, "control after reset")
		`CHK({rx_halt_ff, tx_halt_ff}, 2'h0, "halt after reset")
	endtask

	// Bad first stop bit, blocking, keeping on disable, guarded clear
	task automatic t_framing;
		wr_reg(sres_pkg::OFS_CTRL, 8'h01);
		// Outputs move at the edge the task returns on, so look just after it
		#1 `CHK(rx_en_ff, 1'b1, "receiver not enabled")
		st_u.frame(8'h5a, 1'b0, 2'h2, 1'b1);
		rd_reg(sres_pkg::OFS_STATUS, 8'h96);
		rd_reg(sres_pkg::OFS_RXDATA, 8'h5a);
		`CHK(rx_halt_ff, 1'b1, "reception not halted")
		`CHK(tx_halt_ff, 1'b0, "async transmission halted")
		st_u.frame(8'h11, 1'b0, 2'h3, 1'b0);
		#1 `CHK(rx_data_ff, 8'h5a, "frame taken while blocked")
		wr_reg(sres_pkg::OFS_CTRL, 8'h00);
		rd_reg(sres_pkg::OFS_STATUS, 8'h96);
		wr_reg(sres_pkg::OFS_STATUS, 8'hfe);
		rd_reg(sres_pkg::OFS_STATUS, 8'h96);
		wr_reg(sres_pkg::OFS_STATUS, 8'hfe);
		wr_reg(sres_pkg::OFS_STATUS, 8'h00);
		rd_reg(sres_pkg::OFS_STATUS, 8'h96);
		wr_reg(sres_pkg::OFS_STATUS, 8'h00);
		rd_reg(sres_pkg::OFS_STATUS, 8'h86);
	endtask

	// Second stop bit ignored, then overrun keeps older data
	task automatic t_overrun;
		wr_reg(sres_pkg::OFS_CTRL, 8'h09);
		#1 `CHK({rx_en_ff, stop2_ff, rx_halt_ff}, 3'h6, "two stop bit setup")
		st_u.frame(8'h22, 1'b0, 2'h1, 1'b0);
		rd_reg(sres_pkg::OFS_STATUS, 8'hc4);
		st_u.frame(8'h33, 1'b0, 2'h3, 1'b1);
		#1 `CHK(rx_data_ff, 8'h22, "overrun lost old data")
		wr_reg(sres_pkg::OFS_CTRL, 8'h08);
		rd_reg(sres_pkg::OFS_STATUS, 8'he4);
		wr_reg(sres_pkg::OFS_STATUS, 8'hdf);
		rd_reg(sres_pkg::OFS_STATUS, 8'hc5);
		`CHK(tx_mpb_ff, 1'b1, "transmit multiprocessor bit")
		st_u.pulse(3);
		rd_reg(sres_pkg::OFS_STATUS, 8'h85);
	endtask

	// Even mismatch, blocked reception, sync halt, then clean odd frame
	task automatic t_parity;
		wr_reg(sres_pkg::OFS_CTRL, 8'h11);
		st_u.frame(8'h01, 1'b0, 2'h3, 1'b0);
		rd_reg(sres_pkg::OFS_STATUS, 8'h8d);
		`CHK(rx_data_ff, 8'h01, "parity data not stored")
		st_u.frame(8'h02, 1'b1, 2'h3, 1'b0);
		#1 `CHK(rx_data_ff, 8'h01, "frame taken while blocked")
		wr_reg(sres_pkg::OFS_CTRL, 8'h15);
		repeat (2) @(posedge clk);
		#1 `CHK(tx_halt_ff, 1'b1, "sync transmission not halted")
		`CHK(sync_ff, 1'b1, "sync mode not set")
		wr_reg(sres_pkg::OFS_CTRL, 8'h10);
		rd_reg(sres_pkg::OFS_STATUS, 8'h8d);
		wr_reg(sres_pkg::OFS_STATUS, 8'h01);
		rd_reg(sres_pkg::OFS_STATUS, 8'h85);
		wr_reg(sres_pkg::OFS_CTRL, 8'h31);
		st_u.frame(8'h01, 1'b0, 2'h3, 1'b0);
		rd_reg(sres_pkg::OFS_STATUS, 8'hc5);
		st_u.pulse(3);
	endtask

	// Transmit end: dma clear, last bit with and without empty buffer
	task automatic t_transmit;
		wr_reg(sres_pkg::OFS_CTRL, 8'h02);
		#1 `CHK(tx_en_ff, 1'b1, "transmitter not enabled")
		st_u.pulse(2);
		rd_reg(sres_pkg::OFS_STATUS, 8'h01);
		st_u.pulse(1);
		rd_reg(sres_pkg::OFS_STATUS, 8'h01);
		st_u.pulse(0);
		st_u.pulse(1);
		rd_reg(sres_pkg::OFS_STATUS, 8'h85);
		wr_reg(sres_pkg::OFS_STATUS, 8'h7f);
		rd_reg(sres_pkg::OFS_STATUS, 8'h01);
		wr_reg(sres_pkg::OFS_CTRL, 8'h00);
		rd_reg(sres_pkg::OFS_STATUS, 8'h85);
		wr_reg(sres_pkg::OFS_STATUS, 8'hfe);
		#1 `CHK(tx_mpb_ff, 1'b0, "transmit multiprocessor bit")
	endtask

	// ****************************************
	// Verdict
	// ****************************************
	task automatic stop_test;
		if (n_fail == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Main sequence after 20 reset cycles
	initial
	begin
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		t_reset();
		t_framing();
		t_overrun();
		t_parity();
		t_transmit();
		stop_test();
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (3000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule
